// >>> itpu_pkg.sv
package itpu_pkg;

   localparam int NSRC = 20;
   localparam int NEXT = 7;
   localparam int NCH  = 8;

   // register byte addresses
   localparam logic [11:0] A_SRC_BASE = 12'h000;
   localparam logic [11:0] A_PEC_CTRL = 12'h080;
   localparam logic [11:0] A_PEC_SRCP = 12'h0a0;
   localparam logic [11:0] A_PEC_DSTP = 12'h0c0;
   localparam logic [11:0] A_TFR      = 12'h0e0;
   localparam logic [11:0] A_EDGE     = 12'h0e4;
   localparam logic [11:0] A_STK_UP   = 12'h0e8;
   localparam logic [11:0] A_STK_LO   = 12'h0ec;
   localparam logic [11:0] A_STATUS   = 12'h0f0;

   // source control fields
   localparam int F_LVL    = 0;
   localparam int F_ENA    = 6;
   localparam int F_REQ    = 7;
   localparam int F_PECSEL = 8;
   localparam int F_PECCH  = 9;

   // channel control fields
   localparam int F_CNT    = 0;
   localparam int F_WORD   = 8;
   localparam int F_INCDST = 9;
   localparam int F_CONT   = 10;

   // trap flag register bits
   localparam int T_NMI    = 15;
   localparam int T_STACK_OVER_FLAG  = 14;
   localparam int T_STACK_UNDER_FLAG  = 13;
   localparam int T_BAD_OPCODE_FLAG = 7;
   localparam int T_PROTECTED_FAULT_FLAG = 3;
   localparam int T_ILLOPA = 2;
   localparam int T_BAD_INSTR_ACCESS_FLAG = 1;
   localparam int T_ILLBUS = 0;

   // status fields
   localparam int F_ST_ACT  = 0;
   localparam int F_ST_PRIO = 1;
   localparam int F_ST_IRQ  = 3;

   // hardware traps: 0 nmi, 1 stack over, 2 stack under, 3 class b
   localparam logic [6:0] TRAP_NUM [4] = '{7'h02, 7'h04, 7'h06, 7'h0a};
   localparam logic [1:0] TRAP_PRI [4] = '{2'h3, 2'h2, 2'h2, 2'h1};

   // trap number of each source, in arbitration order
   localparam logic [6:0] SRC_TRAPNUM [NSRC] = '{
      7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h1f,
      7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,
      7'h2a, 7'h47, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f};

   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] WORD_STEP = 16'h0002;

   localparam logic [15:0] STK_UP_RST = 16'h0000;
   localparam logic [15:0] STK_LO_RST = 16'hffff;
   localparam logic [13:0] EDGE_RST   = 14'h0000;

   localparam int CLK_PERIOD_NS = 20;
   localparam int RESP_MIN_NS   = 315;
   localparam int RESP_MAX_NS   = 750;
   localparam int RESP_MIN_CYC  = (RESP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESP_MAX_CYC  = RESP_MAX_NS / CLK_PERIOD_NS;

   typedef enum logic {
      TS_IDLE   = 1'b0,
      TS_ACTIVE = 1'b1
   } itpu_tsvc_t;

endpackage

// >>> itpu_edge_det.sv
`timescale 1ns/100ps
module itpu_edge_det #(
   parameter int W = 8
) (
   input  wire logic           i_mclk,
   input  wire logic           i_rst,
   input  wire logic [W-1:0]   i_pin,
   input  wire logic [2*W-1:0] i_sel,
   output logic      [W-1:0]   o_pulse
);
   import itpu_pkg::*;

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // per-input edge selection
   for (genvar g = 0; g < W; g++) begin : g_edge
      logic [1:0] sel;
      assign sel = i_sel[2*g +: 2];
      assign o_pulse[g] = ((sel == EDGE_RISE || sel == EDGE_BOTH) && s2_reg[g] && !s3_reg[g]) ||
                          ((sel == EDGE_FALL || sel == EDGE_BOTH) && !s2_reg[g] && s3_reg[g]);
   end

endmodule

// >>> itpu_core.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
// Contract
// - each source routes to cpu or transfer
// - transfer steals one cycle, no vector
// - move byte/word, bump source or destination
// - count down per transfer, except continuous
// - count zero raises source's vectored interrupt
// - eight independent transfer channels
// - per-source control: request, enable, level
// - sixteen priority levels
// - only strictly higher priority preempts
// - every source owns its vector
// - fast inputs: rising, falling or both
// - software trap vector is number times four
// - vector table per trap numbers
// - hardware traps non-maskable, own vector
// - hardware trap sets its flag bit
// - trap preempts unless equal or higher trap active
// - no interrupts or transfers during trap
// - class a trap numbers and flags
// - class b shares number 0ah, priority 1
// - response within 315 to 750 ns
// - stack pointer checked against limits
module itpu_core (
   input  wire logic                     i_mclk,
   input  wire logic                     i_rst,
   input  wire logic                     i_psel,
   input  wire logic                     i_penable,
   input  wire logic                     i_pwrite,
   input  wire logic [11:0]              i_paddr,
   input  wire logic [31:0]              i_pwdata,
   output logic      [31:0]              o_prdata,
   output logic                          o_pready,
   output logic                          o_pslverr,
   input  wire logic [itpu_pkg::NEXT-1:0] i_ext_irq,
   input  wire logic                     i_nmi_n,
   input  wire logic [12:0]              i_periph_evt,
   input  wire logic [3:0]               i_cpu_prio,
   output logic                          o_irq_req,
   output logic      [8:0]               o_irq_vector,
   output logic      [3:0]               o_irq_level,
   input  wire logic                     i_irq_ack,
   output logic                          o_xfer_valid,
   output logic      [15:0]              o_xfer_src,
   output logic      [15:0]              o_xfer_dst,
   output logic                          o_xfer_word,
   output logic      [2:0]               o_xfer_chan,
   input  wire logic                     i_bad_opcode,
   input  wire logic                     i_prot_fault,
   input  wire logic                     i_bad_word_acc,
   input  wire logic                     i_bad_instr_acc,
   input  wire logic                     i_bad_bus_acc,
   input  wire logic                     i_stack_access,
   input  wire logic [15:0]              i_sp,
   output logic                          o_trap_req,
   output logic      [8:0]               o_trap_vector,
   input  wire logic                     i_trap_ack,
   input  wire logic                     i_trap_done,
   output logic                          o_trap_active,
   input  wire logic                     i_swtrap_valid,
   input  wire logic [6:0]               i_swtrap_num,
   output logic                          o_swtrap_valid,
   output logic      [8:0]               o_swtrap_vector,
   output logic      [3:0]               o_swtrap_level
);
   import itpu_pkg::*;

   localparam int LAT_MAX = RESP_MAX_CYC;

   logic [3:0]      lvl_reg [NSRC];
   logic [2:0]      pecch_reg [NSRC];
   logic [NSRC-1:0] ena_reg;
   logic [NSRC-1:0] req_reg;
   logic [NSRC-1:0] pecsel_reg;
   logic [7:0]      cnt_reg [NCH];
   logic [15:0]     srcp_reg [NCH];
   logic [15:0]     dstp_reg [NCH];
   logic [NCH-1:0]  word_reg;
   logic [NCH-1:0]  incdst_reg;
   logic [NCH-1:0]  cont_reg;
   logic [15:0]     tfr_reg;
   logic [15:0]     stk_up_reg;
   logic [15:0]     stk_lo_reg;
   logic [13:0]     edge_reg;
   logic [3:0]      trap_pend_reg;
   logic [1:0]      trap_sel_reg;
   logic [1:0]      trap_selp_reg;
   logic [1:0]      trap_prio_reg;
   itpu_tsvc_t      tsvc_reg;
   logic [31:0]     prdata_reg;
   logic            hit_reg;
   logic [4:0]      irq_src_reg;

   logic            acc;
   logic            setup;
   logic            wr;
   logic            a_src;
   logic [4:0]      a_si;
   logic [2:0]      a_ch;
   logic [11:0]     a_blk;
   logic [31:0]     rd_data;
   logic            rd_hit;
   logic [NEXT:0]   pulses;
   logic [NSRC-1:0] ev;
   logic            nmi_evt;
   logic            win_found;
   logic [4:0]      win_idx;
   logic [3:0]      win_lvl;
   logic            win_pec;
   logic            pec_fire;
   logic            cpu_win;
   logic [2:0]      pec_ch;
   logic [7:0]      cnt_sel;
   logic [15:0]     srcp_sel;
   logic [15:0]     step_sel;
   logic [3:0]      trap_evt;
   logic [1:0]      tsel;
   logic [1:0]      cur_prio;
   logic            ovf;
   logic            und;

   // apb decode
   assign acc   = i_psel & i_penable;
   assign setup = i_psel & ~i_penable;
   assign wr    = acc & i_pwrite;
   assign a_si  = i_paddr[6:2];
   assign a_ch  = i_paddr[4:2];
   assign a_blk = {i_paddr[11:5], 5'h00};
   assign a_src = (i_paddr[11:7] == A_SRC_BASE[11:7]) && (a_si < 5'(NSRC));

   always_comb begin
      rd_data = '0;
      rd_hit  = 1'b1;
      if (a_src) begin
         rd_data[F_LVL +: 4]   = lvl_reg[a_si];
         rd_data[F_ENA]        = ena_reg[a_si];
         rd_data[F_REQ]        = req_reg[a_si];
         rd_data[F_PECSEL]     = pecsel_reg[a_si];
         rd_data[F_PECCH +: 3] = pecch_reg[a_si];
      end else if (a_blk == A_PEC_CTRL) begin
         rd_data[F_CNT +: 8] = cnt_reg[a_ch];
         rd_data[F_WORD]     = word_reg[a_ch];
         rd_data[F_INCDST]   = incdst_reg[a_ch];
         rd_data[F_CONT]     = cont_reg[a_ch];
      end else if (a_blk == A_PEC_SRCP) begin
         rd_data[15:0] = srcp_reg[a_ch];
      end else if (a_blk == A_PEC_DSTP) begin
         rd_data[15:0] = dstp_reg[a_ch];
      end else if (i_paddr == A_TFR) begin
         rd_data[15:0] = tfr_reg;
      end else if (i_paddr == A_EDGE) begin
         rd_data[13:0] = edge_reg;
      end else if (i_paddr == A_STK_UP) begin
         rd_data[15:0] = stk_up_reg;
      end else if (i_paddr == A_STK_LO) begin
         rd_data[15:0] = stk_lo_reg;
      end else if (i_paddr == A_STATUS) begin
         rd_data[F_ST_ACT]       = (tsvc_reg == TS_ACTIVE);
         rd_data[F_ST_PRIO +: 2] = trap_prio_reg;
         rd_data[F_ST_IRQ]       = o_irq_req;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         prdata_reg <= '0;
         hit_reg    <= 1'b0;
      end else if (setup) begin
         prdata_reg <= rd_data;
         hit_reg    <= rd_hit;
      end
   end

   assign o_prdata  = prdata_reg;
   assign o_pready  = acc;
   assign o_pslverr = acc & ~hit_reg;

   // pin inputs: fast external lines and nmi
   itpu_edge_det #(.W(NEXT + 1)) u_edge (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_pin   ({i_nmi_n, i_ext_irq}),
      .i_sel   ({EDGE_FALL, edge_reg}),
      .o_pulse (pulses)
   );

   assign ev      = {i_periph_evt, pulses[NEXT-1:0]};
   assign nmi_evt = pulses[NEXT];

   // arbitration
   always_comb begin
      win_found = 1'b0;
      win_idx   = '0;
      win_lvl   = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (req_reg[i] && ena_reg[i] && lvl_reg[i] > i_cpu_prio &&
             tsvc_reg == TS_IDLE) begin
            if (!win_found || lvl_reg[i] > win_lvl) begin
               win_found = 1'b1;
               win_idx   = 5'(i);
               win_lvl   = lvl_reg[i];
            end
         end
      end
   end

   assign pec_ch   = pecch_reg[win_idx];
   assign cnt_sel  = cnt_reg[pec_ch];
   assign srcp_sel = srcp_reg[pec_ch];
   assign step_sel = word_reg[pec_ch] ? WORD_STEP : BYTE_STEP;
   // zero count falls back to vectored service
   assign win_pec  = pecsel_reg[win_idx] && (cnt_sel != 8'h00);
   assign pec_fire = win_found & win_pec;
   assign cpu_win  = win_found & ~win_pec;

   // source control registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ena_reg    <= '0;
         req_reg    <= '0;
         pecsel_reg <= '0;
         for (int i = 0; i < NSRC; i++) begin
            lvl_reg[i]   <= '0;
            pecch_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            if (wr && a_src && a_si == 5'(i)) begin
               lvl_reg[i]    <= i_pwdata[F_LVL +: 4];
               ena_reg[i]    <= i_pwdata[F_ENA];
               req_reg[i]    <= i_pwdata[F_REQ];
               pecsel_reg[i] <= i_pwdata[F_PECSEL];
               pecch_reg[i]  <= i_pwdata[F_PECCH +: 3];
            end
            if ((i_irq_ack && o_irq_req && irq_src_reg == 5'(i)) ||
                (pec_fire && win_idx == 5'(i) &&
                 (cont_reg[pec_ch] || cnt_sel != 8'h01))) begin
               req_reg[i] <= 1'b0;
            end
            if (ev[i]) begin
               req_reg[i] <= 1'b1;
            end
         end
      end
   end

   // transfer channels
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         word_reg   <= '0;
         incdst_reg <= '0;
         cont_reg   <= '0;
         for (int c = 0; c < NCH; c++) begin
            cnt_reg[c]  <= '0;
            srcp_reg[c] <= '0;
            dstp_reg[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (wr && a_blk == A_PEC_CTRL && a_ch == 3'(c)) begin
               cnt_reg[c]    <= i_pwdata[F_CNT +: 8];
               word_reg[c]   <= i_pwdata[F_WORD];
               incdst_reg[c] <= i_pwdata[F_INCDST];
               cont_reg[c]   <= i_pwdata[F_CONT];
            end
            if (wr && a_blk == A_PEC_SRCP && a_ch == 3'(c)) begin
               srcp_reg[c] <= i_pwdata[15:0];
            end
            if (wr && a_blk == A_PEC_DSTP && a_ch == 3'(c)) begin
               dstp_reg[c] <= i_pwdata[15:0];
            end
            if (pec_fire && pec_ch == 3'(c)) begin
               if (!cont_reg[c]) begin
                  cnt_reg[c] <= cnt_reg[c] - 8'h01;
               end
               if (incdst_reg[c]) begin
                  dstp_reg[c] <= dstp_reg[c] + step_sel;
               end else begin
                  srcp_reg[c] <= srcp_reg[c] + step_sel;
               end
            end
         end
      end
   end

   // cpu request and transfer outputs
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_req    <= 1'b0;
         o_irq_vector <= '0;
         o_irq_level  <= '0;
         irq_src_reg  <= '0;
         o_xfer_valid <= 1'b0;
         o_xfer_src   <= '0;
         o_xfer_dst   <= '0;
         o_xfer_word  <= 1'b0;
         o_xfer_chan  <= '0;
      end else begin
         o_irq_req    <= cpu_win & ~i_irq_ack;
         o_irq_vector <= {SRC_TRAPNUM[win_idx], 2'b00};
         o_irq_level  <= win_lvl;
         irq_src_reg  <= win_idx;
         o_xfer_valid <= pec_fire;
         o_xfer_src   <= srcp_sel;
         o_xfer_dst   <= dstp_reg[pec_ch];
         o_xfer_word  <= word_reg[pec_ch];
         o_xfer_chan  <= pec_ch;
      end
   end

   // hardware trap detection
   assign ovf = i_stack_access && (i_sp < stk_up_reg);
   assign und = i_stack_access && (i_sp > stk_lo_reg);
   assign trap_evt = {i_bad_opcode | i_prot_fault | i_bad_word_acc |
                      i_bad_instr_acc | i_bad_bus_acc, und, ovf, nmi_evt};

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tfr_reg    <= '0;
         edge_reg   <= EDGE_RST;
         stk_up_reg <= STK_UP_RST;
         stk_lo_reg <= STK_LO_RST;
      end else begin
         if (wr && i_paddr == A_EDGE) begin
            edge_reg <= i_pwdata[13:0];
         end
         if (wr && i_paddr == A_STK_UP) begin
            stk_up_reg <= i_pwdata[15:0];
         end
         if (wr && i_paddr == A_STK_LO) begin
            stk_lo_reg <= i_pwdata[15:0];
         end
         // software clears by writing zero; a new trap wins
         tfr_reg <= ((wr && i_paddr == A_TFR) ? (tfr_reg & i_pwdata[15:0]) : tfr_reg) |
                    (16'(nmi_evt) << T_NMI) | (16'(ovf) << T_STACK_OVER_FLAG) |
                    (16'(und) << T_STACK_UNDER_FLAG) | (16'(i_bad_opcode) << T_BAD_OPCODE_FLAG) |
                    (16'(i_prot_fault) << T_PROTECTED_FAULT_FLAG) | (16'(i_bad_word_acc) << T_ILLOPA) |
                    (16'(i_bad_instr_acc) << T_BAD_INSTR_ACCESS_FLAG) | (16'(i_bad_bus_acc) << T_ILLBUS);
      end
   end

   always_comb begin
      tsel = 2'h3;
      if (trap_pend_reg[0]) begin
         tsel = 2'h0;
      end else if (trap_pend_reg[1]) begin
         tsel = 2'h1;
      end else if (trap_pend_reg[2]) begin
         tsel = 2'h2;
      end
   end

   assign cur_prio = (tsvc_reg == TS_ACTIVE) ? trap_prio_reg : 2'h0;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         trap_pend_reg <= '0;
         trap_sel_reg  <= '0;
         trap_selp_reg <= '0;
         o_trap_req    <= 1'b0;
         o_trap_vector <= '0;
      end else begin
         trap_pend_reg <= (trap_pend_reg &
                           ~((i_trap_ack && o_trap_req) ? 4'(1) << trap_sel_reg : 4'h0)) |
                          trap_evt;
         trap_sel_reg  <= tsel;
         trap_selp_reg <= TRAP_PRI[tsel];
         o_trap_req    <= (|trap_pend_reg) && (TRAP_PRI[tsel] > cur_prio) &&
                          !i_trap_ack;
         o_trap_vector <= {TRAP_NUM[tsel], 2'b00};
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tsvc_reg      <= TS_IDLE;
         trap_prio_reg <= '0;
      end else begin
         unique case (tsvc_reg)
            TS_IDLE: begin
               if (i_trap_ack && o_trap_req) begin
                  tsvc_reg      <= TS_ACTIVE;
                  trap_prio_reg <= trap_selp_reg;
               end
            end
            TS_ACTIVE: begin
               if (i_trap_ack && o_trap_req) begin
                  trap_prio_reg <= trap_selp_reg;
               end else if (i_trap_done) begin
                  tsvc_reg      <= TS_IDLE;
                  trap_prio_reg <= '0;
               end
            end
         endcase
      end
   end

   assign o_trap_active = (tsvc_reg == TS_ACTIVE);

   // software trap keeps the current cpu level
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_swtrap_valid  <= 1'b0;
         o_swtrap_vector <= '0;
         o_swtrap_level  <= '0;
      end else begin
         o_swtrap_valid  <= i_swtrap_valid;
         o_swtrap_vector <= {i_swtrap_num, 2'b00};
         o_swtrap_level  <= i_cpu_prio;
      end
   end

   // checks
   a_cnt_dec: assert property (@(posedge i_mclk) disable iff (i_rst)
      pec_fire && !cont_reg[pec_ch] |=> cnt_reg[$past(pec_ch)] == $past(cnt_sel) - 8'h01)
      else $error("channel count not decremented");
   a_cnt_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
      pec_fire && cont_reg[pec_ch] && !wr |=> cnt_reg[$past(pec_ch)] == $past(cnt_sel))
      else $error("continuous channel count changed");
   a_src_step: assert property (@(posedge i_mclk) disable iff (i_rst)
      pec_fire && !incdst_reg[pec_ch] |=> srcp_reg[$past(pec_ch)] == $past(srcp_sel) + $past(step_sel))
      else $error("source pointer not stepped");
   a_xfer_once: assert property (@(posedge i_mclk) disable iff (i_rst)
      pec_fire |=> o_xfer_valid && o_xfer_src == $past(srcp_sel) && !o_irq_req)
      else $error("transfer not issued in one cycle");
   a_irq_above: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_irq_req |-> o_irq_level > $past(i_cpu_prio))
      else $error("request not above cpu level");
   a_trap_blocks: assert property (@(posedge i_mclk) disable iff (i_rst)
      tsvc_reg == TS_ACTIVE |=> !o_irq_req && !o_xfer_valid)
      else $error("service during trap");
   a_nmi_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
      nmi_evt && tsvc_reg == TS_IDLE && !o_trap_req |=>
      tfr_reg[T_NMI] ##1 o_trap_req && o_trap_vector == 9'h008)
      else $error("nmi not flagged or vectored");
   a_swtrap_vec: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_swtrap_valid |=> o_swtrap_valid && o_swtrap_vector == {$past(i_swtrap_num), 2'b00})
      else $error("software trap vector wrong");
   a_irq_latency: assert property (@(posedge i_mclk) disable iff (i_rst)
      cpu_win && !i_irq_ack && !i_trap_ack |-> ##[1:LAT_MAX] o_irq_req)
      else $error("request not presented in time");

   c_pec: cover property (@(posedge i_mclk) disable iff (i_rst) pec_fire ##1 o_xfer_valid);
   c_irq: cover property (@(posedge i_mclk) disable iff (i_rst) o_irq_req && i_irq_ack);
   c_trap: cover property (@(posedge i_mclk) disable iff (i_rst) o_trap_req && i_trap_ack);
   c_zero: cover property (@(posedge i_mclk) disable iff (i_rst)
      pec_fire && cnt_sel == 8'h01 && !cont_reg[pec_ch]);

endmodule

// >>> itpu_cpu_model.sv
`timescale 1ns/100ps
module itpu_cpu_model (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_irq_req,
   input  wire logic i_trap_req,
   input  wire logic i_trap_active,
   input  wire logic i_hold,
   output logic      o_irq_ack,
   output logic      o_trap_ack,
   output logic      o_trap_done
);
   logic [2:0] cnt_reg;
   // one ack per request, late while held; service ends after a few cycles
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_ack   <= 1'b0;
         o_trap_ack  <= 1'b0;
         cnt_reg     <= 3'h0;
         o_trap_done <= 1'b0;
      end else begin
         o_irq_ack   <= i_irq_req & ~o_irq_ack & ~i_hold;
         o_trap_ack  <= i_trap_req & ~o_trap_ack & ~i_hold;
         cnt_reg     <= i_trap_active ? cnt_reg + 3'h1 : 3'h0;
         o_trap_done <= (cnt_reg == 3'h4);
      end
   end
endmodule

// >>> itpu_core_tb_top.sv
`timescale 1ns/100ps
module itpu_core_tb_top;
   import itpu_pkg::*;
   logic        i_mclk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
   logic        i_pwrite = 1'b0, i_nmi_n = 1'b1, hold = 1'b0, err, i_swtrap_valid;
   logic        o_pready, o_pslverr, o_irq_req, i_irq_ack, o_xfer_valid, o_xfer_word;
   logic        o_trap_req, i_trap_ack, i_trap_done, o_trap_active, o_swtrap_valid;
   logic        i_bad_opcode, i_prot_fault, i_bad_word_acc, i_bad_instr_acc;
   logic        i_bad_bus_acc, i_stack_access;
   logic [11:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, rd;
   logic [6:0]  i_ext_irq = '0, i_swtrap_num = '0;
   logic [12:0] i_periph_evt;
   logic [3:0]  i_cpu_prio = 4'h0, o_irq_level, o_swtrap_level;
   logic [8:0]  o_irq_vector, o_trap_vector, o_swtrap_vector;
   logic [15:0] o_xfer_src, o_xfer_dst, i_sp = 16'h0000;
   logic [2:0]  o_xfer_chan;
   int          mismatches = 0, compares = 0;
   initial {i_swtrap_valid, i_stack_access, i_bad_opcode, i_prot_fault, i_bad_word_acc,
            i_bad_instr_acc, i_bad_bus_acc, i_periph_evt} = '0;
   always #10 i_mclk = ~i_mclk;
   itpu_core uut (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_ext_irq, .i_nmi_n, .i_periph_evt, .i_cpu_prio,
      .o_irq_req, .o_irq_vector, .o_irq_level, .i_irq_ack, .o_xfer_valid, .o_xfer_src,
      .o_xfer_dst, .o_xfer_word, .o_xfer_chan, .i_bad_opcode, .i_prot_fault,
      .i_bad_word_acc, .i_bad_instr_acc, .i_bad_bus_acc, .i_stack_access, .i_sp,
      .o_trap_req, .o_trap_vector, .i_trap_ack, .i_trap_done, .o_trap_active,
      .i_swtrap_valid, .i_swtrap_num, .o_swtrap_valid, .o_swtrap_vector, .o_swtrap_level);
   itpu_cpu_model cpu (.i_mclk, .i_rst, .i_irq_req(o_irq_req), .i_trap_req(o_trap_req),
      .i_trap_active(o_trap_active), .i_hold(hold), .o_irq_ack(i_irq_ack),
      .o_trap_ack(i_trap_ack), .o_trap_done(i_trap_done));
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic limit(input int n);
      if (n >= 60) begin
         mismatches++;
         results();
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1 && n < 60);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      limit(n);
   endtask
   task automatic waitfor(input int k);
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         #1;
         n++;
      end while ((k == 0 ? o_irq_req : k == 1 ? o_xfer_valid : o_trap_req) !== 1'b1
                 && n < 60);
      limit(n);
   endtask
   // one-cycle pulse on bundle bit k
   task automatic pulse(input int k);
      @(posedge i_mclk);
      {i_swtrap_valid, i_stack_access, i_bad_opcode, i_prot_fault, i_bad_word_acc,
       i_bad_instr_acc, i_bad_bus_acc, i_periph_evt} <= 20'h00001 << k;
      @(posedge i_mclk);
      {i_swtrap_valid, i_stack_access, i_bad_opcode, i_prot_fault, i_bad_word_acc,
       i_bad_instr_acc, i_bad_bus_acc, i_periph_evt} <= '0;
   endtask
   task automatic trapc(input logic [8:0] vec);
      waitfor(2);
      chk(o_trap_vector, vec);
      repeat (12) @(posedge i_mclk);
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      apb(1'b0, A_STK_LO, '0);
      chk(rd, 40'hffff);
      apb(1'b0, 12'h0f8, '0);
      chk(err, 40'h1);
      i_cpu_prio <= 4'h5;
      hold <= 1'b1;
      apb(1'b1, A_SRC_BASE + 12'h01c, 32'h45);
      pulse(0);
      repeat (6) @(posedge i_mclk);
      chk(o_irq_req, 40'h0);
      apb(1'b0, A_SRC_BASE + 12'h01c, '0);
      chk(rd, 40'hc5);
      i_cpu_prio <= 4'h4;
      waitfor(0);
      repeat (3) @(posedge i_mclk);
      chk({o_irq_vector, o_irq_level}, {9'h088, 4'h5});
      hold <= 1'b0;
      repeat (4) @(posedge i_mclk);
      apb(1'b0, A_SRC_BASE + 12'h01c, '0);
      chk(rd, 40'h45);
      apb(1'b1, A_PEC_CTRL + 12'h008, 32'h102);
      apb(1'b1, A_PEC_SRCP + 12'h008, 32'h1000);
      apb(1'b1, A_PEC_DSTP + 12'h008, 32'h2000);
      apb(1'b1, A_SRC_BASE + 12'h020, 32'h547);
      pulse(1);
      waitfor(1);
      chk({o_xfer_chan, o_xfer_word, o_xfer_src, o_xfer_dst}, {4'h5, 32'h10002000});
      pulse(1);
      waitfor(1);
      chk(o_xfer_src, 40'h1002);
      waitfor(0);
      chk(o_irq_vector, 40'h08c);
      apb(1'b0, A_PEC_CTRL + 12'h008, '0);
      chk(rd, 40'h100);
      apb(1'b1, A_EDGE, {30'h0, EDGE_RISE});
      apb(1'b1, A_SRC_BASE, 32'h46);
      i_ext_irq <= 7'h01;
      waitfor(0);
      chk(o_irq_vector, 40'h064);
      apb(1'b1, A_PEC_CTRL + 12'h008, 32'h601);
      pulse(1);
      waitfor(1);
      chk(o_xfer_dst, 40'h2000);
      pulse(1);
      waitfor(1);
      chk(o_xfer_dst, 40'h2001);
      apb(1'b0, A_PEC_CTRL + 12'h008, '0);
      chk(rd, 40'h601);
      i_swtrap_num <= 7'h7f;
      pulse(19);
      #1;
      chk({o_swtrap_valid, o_swtrap_vector, o_swtrap_level}, {1'b1, 9'h1fc, 4'h4});
      @(posedge i_mclk);
      i_nmi_n <= 1'b0;
      trapc(9'h008);
      apb(1'b1, A_STK_UP, 32'h100);
      i_sp <= 16'h0080;
      pulse(18);
      trapc(9'h010);
      for (int k = 13; k < 18; k++)
         trapc_b(k);
      apb(1'b0, A_TFR, '0);
      chk(rd, 40'hc08f);
      results();
   end
   task automatic trapc_b(input int k);
      pulse(k);
      trapc(9'h028);
   endtask
   initial begin
      repeat (20000) @(posedge i_mclk);
      mismatches++;
      results();
   end
endmodule
